// *** common/xbsa_pkg.sv ***
// What this block does
// - Take every master access at once; forward it same cycle when the port is free.
// - Hold a master in wait states while its target port is busy or parked elsewhere.
// - Grant a newly targeted port only after the earlier access elsewhere has completed.
// - A granted master keeps its port until another requesting master wins arbitration for it.
// - A higher-priority request to the same port takes ownership away.
// - Complete master IDLE transfers locally without involving any slave bus.
// - Drive IDLE on a slave bus whenever no master is requesting that port.
// - An idled slave port stays parked on the last master that used it.
// - Bit 9 of the platform control register selects the arbitration policy.
// - Processor core is master port 0; converter bus master is master port 3.
// - Three slave ports: 0 flash controller, 1 SRAM controller, 2 peripheral bridge.
// - Up to three masters run concurrently on different slaves; arbitrate only contention.
// - All paths carry 32-bit data; the switch runs on the masters' clock.
// - No switch registers; the only control is the arbitration select bit.
// - Arbitration select 0 is fixed priority, 1 is round-robin, for every port.
// - A burst locks arbitration on its port during its SEQ and BUSY beats; the port can still change hands on its NONSEQ beat.
// - Fixed priority: highest-numbered requester wins; ownership rechecked on every edge where the port is ready and unlocked.
// - Round-robin: rank by distance ahead of last master; switch at transfer boundary.
package xbsa_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_MST = 4;
    localparam int NUM_SLV = 3;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int REG_ADDR_W = 12;

    // ----------------------------------------------------------------
    // Port assignments
    // ----------------------------------------------------------------
    localparam logic [1:0] MST_CORE = 2'h0;
    localparam logic [1:0] MST_CONVERTER = 2'h3;
    localparam logic [1:0] SLV_FLASH = 2'h0;
    localparam logic [1:0] SLV_SRAM = 2'h1;
    localparam logic [1:0] SLV_BRIDGE = 2'h2;

    // ----------------------------------------------------------------
    // Address regions, selected by the top three address bits
    // ----------------------------------------------------------------
    localparam int REGION_MSB = 31;
    localparam int REGION_LSB = 29;
    localparam logic [2:0] REGION_FLASH = 3'h0;
    localparam logic [2:0] REGION_SRAM = 3'h1;

    // ----------------------------------------------------------------
    // Platform control register
    // ----------------------------------------------------------------
    localparam logic [REG_ADDR_W-1:0] PLATFORM_CONTROL_OFFSET = 12'h00C;
    localparam int ARB_SEL_BIT = 9;
    localparam logic ARB_SEL_RESET = 1'h0;
    localparam logic ARB_FIXED = 1'h0;
    localparam logic ARB_ROUND_ROBIN = 1'h1;
    localparam logic [1:0] OWNER_RESET = 2'h0;

    // ----------------------------------------------------------------
    // Transfer types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TRANS_IDLE = 2'b00,
        TRANS_BUSY = 2'b01,
        TRANS_NONSEQ = 2'b10,
        TRANS_SEQ = 2'b11
    } xbsa_trans_t;

endpackage

// *** logic/xbsa_top.sv ***
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module xbsa_top
    import xbsa_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Master side address phase.
    input wire logic [NUM_MST-1:0][1:0] m_htrans,
    input wire logic [NUM_MST-1:0][ADDR_W-1:0] m_haddr,
    input wire logic [NUM_MST-1:0] m_hwrite,
    input wire logic [NUM_MST-1:0][2:0] m_hsize,
    input wire logic [NUM_MST-1:0][DATA_W-1:0] m_hwdata,
    // Master side response.
    output logic [NUM_MST-1:0] m_hready,
    output logic [NUM_MST-1:0] m_hresp,
    output logic [NUM_MST-1:0][DATA_W-1:0] m_hrdata,
    // Slave side address phase.
    output logic [NUM_SLV-1:0][1:0] s_htrans,
    output logic [NUM_SLV-1:0][ADDR_W-1:0] s_haddr,
    output logic [NUM_SLV-1:0] s_hwrite,
    output logic [NUM_SLV-1:0][2:0] s_hsize,
    output logic [NUM_SLV-1:0][DATA_W-1:0] s_hwdata,
    // Slave side response.
    input wire logic [NUM_SLV-1:0] s_hreadyout,
    input wire logic [NUM_SLV-1:0] s_hresp,
    input wire logic [NUM_SLV-1:0][DATA_W-1:0] s_hrdata,
    // Platform control register port.
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic [1:0] slv_decode(input logic [ADDR_W-1:0] addr);
        logic [2:0] region;
        region = addr[REGION_MSB:REGION_LSB];
        if (region == REGION_FLASH) begin
            slv_decode = SLV_FLASH;
        end else if (region == REGION_SRAM) begin
            slv_decode = SLV_SRAM;
        end else begin
            slv_decode = SLV_BRIDGE;
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic arb_sel_q;
    logic [NUM_MST-1:0] pend_q;
    xbsa_trans_t hold_trans_q [NUM_MST];
    logic [NUM_MST-1:0][ADDR_W-1:0] hold_addr_q;
    logic [NUM_MST-1:0] hold_write_q;
    logic [NUM_MST-1:0][2:0] hold_size_q;
    logic [NUM_MST-1:0] dp_act_q;
    logic [NUM_MST-1:0][1:0] dp_slv_q;
    logic [NUM_SLV-1:0][1:0] owner_q;
    logic [NUM_SLV-1:0][1:0] owner_d;
    logic [NUM_SLV-1:0] sdp_act_q;
    logic [NUM_SLV-1:0][1:0] sdp_mst_q;

    xbsa_trans_t e_trans [NUM_MST];
    logic [NUM_MST-1:0][ADDR_W-1:0] e_addr;
    logic [NUM_MST-1:0] e_write;
    logic [NUM_MST-1:0][2:0] e_size;
    logic [NUM_MST-1:0][1:0] e_slv;
    logic [NUM_MST-1:0] m_rdy;
    logic [NUM_MST-1:0] req;
    logic [NUM_MST-1:0] fwd;
    logic [NUM_SLV-1:0] sel;
    logic [NUM_SLV-1:0] lock;
    logic [NUM_SLV-1:0][NUM_MST-1:0] req_to;

    // ----------------------------------------------------------------
    // Platform control register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            arb_sel_q <= ARB_SEL_RESET;
        end else if (reg_wr && reg_addr == PLATFORM_CONTROL_OFFSET) begin
            arb_sel_q <= reg_wdata[ARB_SEL_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd && reg_addr == PLATFORM_CONTROL_OFFSET) begin
            reg_rdata <= DATA_W'({arb_sel_q, {ARB_SEL_BIT{1'b0}}});
        end else begin
            reg_rdata <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Master side: effective request and local response
    // ----------------------------------------------------------------
    always_comb begin
        for (int m = 0; m < NUM_MST; m++) begin
            e_trans[m] = pend_q[m] ? hold_trans_q[m] : xbsa_trans_t'(m_htrans[m]);
            e_addr[m] = pend_q[m] ? hold_addr_q[m] : m_haddr[m];
            e_write[m] = pend_q[m] ? hold_write_q[m] : m_hwrite[m];
            e_size[m] = pend_q[m] ? hold_size_q[m] : m_hsize[m];
            e_slv[m] = slv_decode(e_addr[m]);
            // A held access keeps the master waiting; IDLE data phases finish here.
            if (pend_q[m]) begin
                m_rdy[m] = 1'b0;
            end else if (dp_act_q[m]) begin
                m_rdy[m] = s_hreadyout[dp_slv_q[m]];
            end else begin
                m_rdy[m] = 1'b1;
            end
            // A live access counts only once the previous data phase has ended.
            req[m] = pend_q[m] | (m_htrans[m][1] & m_rdy[m]);
            fwd[m] = req[m] && owner_q[e_slv[m]] == 2'(m) && s_hreadyout[e_slv[m]];
        end
    end

    always_comb begin
        for (int m = 0; m < NUM_MST; m++) begin
            m_hready[m] = m_rdy[m];
            m_hresp[m] = dp_act_q[m] ? s_hresp[dp_slv_q[m]] : 1'b0;
            m_hrdata[m] = s_hrdata[dp_slv_q[m]];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pend_q <= '0;
        end else begin
            pend_q <= req & ~fwd;
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int m = 0; m < NUM_MST; m++) begin
            if (reset) begin
                hold_trans_q[m] <= TRANS_IDLE;
                hold_addr_q[m] <= '0;
                hold_write_q[m] <= 1'b0;
                hold_size_q[m] <= '0;
            end else if (!pend_q[m] && req[m] && !fwd[m]) begin
                hold_trans_q[m] <= e_trans[m];
                hold_addr_q[m] <= e_addr[m];
                hold_write_q[m] <= e_write[m];
                hold_size_q[m] <= e_size[m];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int m = 0; m < NUM_MST; m++) begin
            if (reset) begin
                dp_act_q[m] <= 1'b0;
                dp_slv_q[m] <= SLV_FLASH;
            end else if (fwd[m]) begin
                dp_act_q[m] <= 1'b1;
                dp_slv_q[m] <= e_slv[m];
            end else if (m_rdy[m]) begin
                dp_act_q[m] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Slave side: arbitration per port
    // ----------------------------------------------------------------
    always_comb begin
        logic [1:0] own;
        logic [1:0] cand;
        logic found;
        own = '0;
        cand = '0;
        found = 1'b0;
        for (int s = 0; s < NUM_SLV; s++) begin
            own = owner_q[s];
            for (int m = 0; m < NUM_MST; m++) begin
                req_to[s][m] = req[m] && e_slv[m] == 2'(s);
            end
            sel[s] = req_to[s][own];
            // A burst beat or busy slot of the owner keeps the port.
            lock[s] = e_slv[own] == 2'(s) && (e_trans[own] == TRANS_SEQ || e_trans[own] == TRANS_BUSY);
            owner_d[s] = own;
            if (s_hreadyout[s] && !lock[s]) begin
                if (arb_sel_q == ARB_FIXED) begin
                    for (int m = 0; m < NUM_MST; m++) begin
                        if (req_to[s][m]) begin
                            owner_d[s] = 2'(m);
                        end
                    end
                end else begin
                    found = 1'b0;
                    for (int k = 1; k <= NUM_MST; k++) begin
                        cand = own + 2'(k);
                        if (!found && req_to[s][cand]) begin
                            owner_d[s] = cand;
                            found = 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            owner_q <= {NUM_SLV{OWNER_RESET}};
        end else begin
            owner_q <= owner_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int s = 0; s < NUM_SLV; s++) begin
            if (reset) begin
                sdp_act_q[s] <= 1'b0;
                sdp_mst_q[s] <= OWNER_RESET;
            end else if (s_hreadyout[s]) begin
                sdp_act_q[s] <= sel[s];
                sdp_mst_q[s] <= owner_q[s];
            end
        end
    end

    always_comb begin
        for (int s = 0; s < NUM_SLV; s++) begin
            s_htrans[s] = sel[s] ? e_trans[owner_q[s]] : TRANS_IDLE;
            s_haddr[s] = e_addr[owner_q[s]];
            s_hwrite[s] = e_write[owner_q[s]];
            s_hsize[s] = e_size[owner_q[s]];
            s_hwdata[s] = m_hwdata[sdp_mst_q[s]];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_reset_state: assert property (disable iff (1'b0) reset |=> owner_q == '0 && arb_sel_q == ARB_FIXED)
        else $error("reset did not park ports on master 0 with fixed priority");

    a_reg_readback: assert property (reg_rd && reg_addr == PLATFORM_CONTROL_OFFSET
        |=> reg_rdata[ARB_SEL_BIT] == $past(arb_sel_q) && reg_rdata[ARB_SEL_BIT-1:0] == '0)
        else $error("platform control readback mismatch");

    for (genvar m = 0; m < NUM_MST; m++) begin : g_mchk
        a_idle_local: assert property (!pend_q[m] && m_rdy[m] && m_htrans[m] == TRANS_IDLE
            |=> m_hready[m] && !m_hresp[m])
            else $error("master idle transfer not completed locally");
        a_wait_held: assert property (req[m] && !fwd[m] |=> !m_hready[m] [*1] ##0 pend_q[m])
            else $error("unserved master not held in wait");
        a_prior_done: assert property (fwd[m] && dp_act_q[m] |-> s_hreadyout[dp_slv_q[m]])
            else $error("new port granted before earlier access completed");
    end

    for (genvar s = 0; s < NUM_SLV; s++) begin : g_schk
        a_same_cycle: assert property (req_to[s][owner_q[s]] && s_hreadyout[s]
            |-> s_htrans[s] == e_trans[owner_q[s]] ##1 sdp_act_q[s])
            else $error("free port did not take access in same cycle");
        a_idle_drive: assert property (req_to[s] == '0 |-> s_htrans[s] == TRANS_IDLE)
            else $error("slave bus not idled without requests");
        a_park_hold: assert property (req_to[s] == '0 ##0 !lock[s] |=> $stable(owner_q[s]))
            else $error("idle port did not stay parked");
        a_burst_lock: assert property (lock[s] |=> owner_q[s] == $past(owner_q[s]))
            else $error("burst lost its port");
        a_fixed_win: assert property (arb_sel_q == ARB_FIXED && s_hreadyout[s] && !lock[s]
            && req_to[s][MST_CONVERTER] |=> owner_q[s] == MST_CONVERTER)
            else $error("highest master did not win fixed arbitration");
        a_rr_next: assert property (arb_sel_q == ARB_ROUND_ROBIN && s_hreadyout[s] && !lock[s]
            && owner_q[s] == 2'h1 && req_to[s] == 4'h5 |=> owner_q[s] == 2'h2)
            else $error("round robin picked wrong master");
        c_contend: cover property (req_to[s][0] && req_to[s][3]);
        c_handover: cover property (s_hreadyout[s] && owner_q[s] != owner_d[s]);
    end

    c_concurrent: cover property (fwd[0] && fwd[3] && e_slv[0] != e_slv[3]);
    c_rr_mode: cover property (arb_sel_q == ARB_ROUND_ROBIN && fwd[1]);

endmodule
`default_nettype wire

// *** test/xbsa_slave_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module xbsa_slave_model
    import xbsa_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Wait states for each slave.
    input wire logic [NUM_SLV-1:0][3:0] wait_cycles,
    // Slave bus from the switch.
    input wire logic [NUM_SLV-1:0][1:0] s_htrans,
    input wire logic [NUM_SLV-1:0][ADDR_W-1:0] s_haddr,
    input wire logic [NUM_SLV-1:0] s_hwrite,
    input wire logic [NUM_SLV-1:0][DATA_W-1:0] s_hwdata,
    // Responses to the switch.
    output logic [NUM_SLV-1:0] s_hreadyout,
    output logic [NUM_SLV-1:0] s_hresp,
    output logic [NUM_SLV-1:0][DATA_W-1:0] s_hrdata
);
    logic [DATA_W-1:0] mem_q [NUM_SLV][16];
    logic [NUM_SLV-1:0] busy_q;
    logic [NUM_SLV-1:0] wr_q;
    logic [NUM_SLV-1:0][3:0] idx_q;
    logic [NUM_SLV-1:0][3:0] cnt_q;

    // Read data is valid only in the last data phase cycle, inverted otherwise.
    always_comb begin
        for (int i = 0; i < NUM_SLV; i++) begin
            s_hreadyout[i] = !busy_q[i] || (cnt_q[i] == 4'h0);
            s_hresp[i] = 1'b0;
            if (busy_q[i] && !wr_q[i] && cnt_q[i] == 4'h0) begin
                s_hrdata[i] = mem_q[i][idx_q[i]];
            end else begin
                s_hrdata[i] = ~mem_q[i][idx_q[i]];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_SLV; i++) begin
            if (reset) begin
                busy_q[i] <= 1'b0;
                cnt_q[i] <= 4'h0;
            end else if (s_hreadyout[i]) begin
                if (busy_q[i] && wr_q[i]) begin
                    mem_q[i][idx_q[i]] <= s_hwdata[i];
                end
                busy_q[i] <= s_htrans[i][1];
                wr_q[i] <= s_hwrite[i];
                idx_q[i] <= s_haddr[i][5:2];
                cnt_q[i] <= wait_cycles[i];
            end else begin
                cnt_q[i] <= cnt_q[i] - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** test/xbsa_top_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module xbsa_top_bench
    import xbsa_pkg::*;
;
    logic ref_clk, reset, reg_wr, reg_rd;
    logic [NUM_MST-1:0][1:0] m_htrans;
    logic [NUM_MST-1:0][ADDR_W-1:0] m_haddr;
    logic [NUM_MST-1:0] m_hwrite, m_hready, m_hresp;
    logic [NUM_MST-1:0][2:0] m_hsize;
    logic [NUM_MST-1:0][DATA_W-1:0] m_hwdata, m_hrdata;
    logic [NUM_SLV-1:0][1:0] s_htrans;
    logic [NUM_SLV-1:0][ADDR_W-1:0] s_haddr;
    logic [NUM_SLV-1:0] s_hwrite, s_hreadyout, s_hresp;
    logic [NUM_SLV-1:0][2:0] s_hsize;
    logic [NUM_SLV-1:0][DATA_W-1:0] s_hwdata, s_hrdata;
    logic [NUM_SLV-1:0][3:0] wait_cycles;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [31:0] rd [4];
    logic [31:0] adr [3] = '{32'h0000_0010, 32'h2000_0014, 32'h4000_0018};
    logic [31:0] pat [3] = '{32'h1111_0000, 32'h2222_0001, 32'h3333_0002};
    int lat [4];
    int cycle = 0;
    int fail_count = 0;
    int samples_checked = 0;

    xbsa_top u_xbsa_top (.ref_clk(ref_clk), .reset(reset), .m_htrans(m_htrans), .m_haddr(m_haddr),
        .m_hwrite(m_hwrite), .m_hsize(m_hsize), .m_hwdata(m_hwdata), .m_hready(m_hready),
        .m_hresp(m_hresp), .m_hrdata(m_hrdata), .s_htrans(s_htrans), .s_haddr(s_haddr),
        .s_hwrite(s_hwrite), .s_hsize(s_hsize), .s_hwdata(s_hwdata), .s_hreadyout(s_hreadyout),
        .s_hresp(s_hresp), .s_hrdata(s_hrdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    xbsa_slave_model u_xbsa_slave_model (.ref_clk(ref_clk), .reset(reset), .wait_cycles(wait_cycles),
        .s_htrans(s_htrans), .s_haddr(s_haddr), .s_hwrite(s_hwrite), .s_hwdata(s_hwdata),
        .s_hreadyout(s_hreadyout), .s_hresp(s_hresp), .s_hrdata(s_hrdata));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycle <= cycle + 1;
        if (cycle == 3000) begin
            fail_count++;
            test_done();
        end
    end

    task test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task reg_write(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task reg_read(input logic [11:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask

    // One single transfer; latency counts clock edges from request to end of data phase.
    task automatic xfer(input int m, input logic [31:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] d, output int l);
        int t0;
        t0 = cycle;
        m_htrans[m] <= TRANS_NONSEQ;
        m_haddr[m] <= a;
        m_hwrite[m] <= w;
        m_hsize[m] <= 3'h2;
        do @(negedge ref_clk); while (m_hready[m] !== 1'b1);
        @(posedge ref_clk);
        m_htrans[m] <= TRANS_IDLE;
        m_hwdata[m] <= wd;
        do @(negedge ref_clk); while (m_hready[m] !== 1'b1);
        d = m_hrdata[m];
        @(posedge ref_clk);
        l = cycle - t0;
    endtask

    // Two-beat incrementing read burst; latency counts clock edges to the end of the last beat.
    task automatic burst2(input int m, input logic [31:0] a, output logic [31:0] d0,
                          output logic [31:0] d1, output int l);
        int t0;
        t0 = cycle;
        m_htrans[m] <= TRANS_NONSEQ;
        m_haddr[m] <= a;
        m_hwrite[m] <= 1'b0;
        m_hsize[m] <= 3'h2;
        do @(negedge ref_clk); while (m_hready[m] !== 1'b1);
        @(posedge ref_clk);
        m_htrans[m] <= TRANS_SEQ;
        m_haddr[m] <= a + 32'h0000_0004;
        do @(negedge ref_clk); while (m_hready[m] !== 1'b1);
        d0 = m_hrdata[m];
        @(posedge ref_clk);
        m_htrans[m] <= TRANS_IDLE;
        do @(negedge ref_clk); while (m_hready[m] !== 1'b1);
        d1 = m_hrdata[m];
        @(posedge ref_clk);
        l = cycle - t0;
    endtask

    task par3(input logic w);
        fork
            xfer(0, adr[0], w, pat[0], rd[0], lat[0]);
            xfer(1, adr[1], w, pat[1], rd[1], lat[1]);
            xfer(2, adr[2], w, pat[2], rd[2], lat[2]);
        join
    endtask

    initial begin
        reset = 1'b1;
        {m_htrans, m_haddr, m_hwrite, m_hsize, m_hwdata} = '0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        wait_cycles = '0;
        @(negedge ref_clk);
        check("hready in reset", 32'h0000_000f, 32'(m_hready));
        check("slave idle in reset", 32'h0000_0000, 32'(s_htrans));
        @(posedge ref_clk);
        reset <= 1'b0;
        reg_read(12'h00C, rd[0]);
        check("select reset", 32'h0000_0000, rd[0]);
        reg_write(12'h00C, 32'hFFFF_FFFF);
        reg_read(12'h00C, rd[0]);
        check("select bit", 32'h0000_0200, rd[0]);
        reg_read(12'h010, rd[0]);
        check("unmapped read", 32'h0000_0000, rd[0]);
        reg_write(12'h00C, 32'h0000_0000);
        $display("test registers done");
        par3(1'b1);
        check("parked write latency", 32'(2), 32'(lat[0]));
        check("unparked write latency", 32'(3), 32'(lat[1]));
        par3(1'b0);
        for (int i = 0; i < 3; i++) begin
            check("read data", pat[i], rd[i]);
            check("parked read latency", 32'(2), 32'(lat[i]));
        end
        $display("test concurrent done");
        xfer(3, adr[2], 1'b0, '0, rd[3], lat[3]);
        check("bridge data", pat[2], rd[3]);
        check("wait for parked port", 32'(3), 32'(lat[3]));
        xfer(3, adr[2], 1'b0, '0, rd[3], lat[3]);
        check("repeat latency", 32'(2), 32'(lat[3]));
        $display("test parking done");
        wait_cycles[SLV_SRAM] <= 4'h2;
        fork
            xfer(1, adr[1], 1'b0, '0, rd[1], lat[1]);
            xfer(3, adr[1], 1'b0, '0, rd[3], lat[3]);
        join
        check("parked owner latency", 32'h0000_0004, 32'(lat[1]));
        check("preempted wait latency", 32'h0000_0007, 32'(lat[3]));
        check("contended data", pat[1], rd[1]);
        check("converter data", pat[1], rd[3]);
        fork
            xfer(1, adr[1], 1'b0, '0, rd[1], lat[1]);
            xfer(2, adr[1], 1'b0, '0, rd[2], lat[2]);
        join
        check("fixed winner", 32'h0000_0001, 32'(lat[2] < lat[1]));
        check("fixed loser latency", 32'h0000_0009, 32'(lat[1]));
        check("fixed loser data", pat[1], rd[1]);
        reg_write(12'h00C, 32'h0000_0200);
        fork
            xfer(0, adr[1], 1'b0, '0, rd[0], lat[0]);
            xfer(2, adr[1], 1'b0, '0, rd[2], lat[2]);
        join
        check("rotating winner", 32'h0000_0001, 32'(lat[2] < lat[0]));
        check("rotating data", pat[1], rd[2]);
        check("rotating loser latency", 32'h0000_0008, 32'(lat[0]));
        $display("test arbitration done");
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        reg_read(12'h00C, rd[0]);
        check("select after reset", 32'h0000_0000, rd[0]);
        xfer(0, adr[2], 1'b0, '0, rd[0], lat[0]);
        check("reset parked latency", 32'h0000_0002, 32'(lat[0]));
        check("reset bridge data", pat[2], rd[0]);
        $display("test reset done");
        xfer(0, 32'h2000_0018, 1'b1, pat[2], rd[0], lat[0]);
        fork
            burst2(0, adr[1], rd[0], rd[1], lat[0]);
            begin
                @(posedge ref_clk);
                xfer(3, adr[1], 1'b0, '0, rd[3], lat[3]);
            end
        join
        check("burst first beat", pat[1], rd[0]);
        check("burst second beat", pat[2], rd[1]);
        check("burst latency", 32'h0000_0007, 32'(lat[0]));
        check("blocked converter latency", 32'h0000_000a, 32'(lat[3]));
        check("blocked converter data", pat[1], rd[3]);
        $display("test burst done");
        test_done();
    end
endmodule
`default_nettype wire
